// ---- gear_pkg.sv ----
/*
  Shared constants, register map and carrier types for the four-axis
  gearing, velocity trim and simultaneous start block.
  Assumes a 200 MHz clock and a 32-bit classic Wishbone register bus.
*/
package gear_pkg;
  localparam int AXES = 4;
  localparam int CLK_MHZ = 200;
  localparam int SAMPLE_US = 341;
  localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
  localparam int START_WIN_US = 100;
  localparam int START_WIN_CYC = START_WIN_US * CLK_MHZ;
  localparam int VEL_FRAC = 16;
  localparam int PROD_W = 48;
  localparam int BYTE_W = 8;
  localparam logic [5:0] DIV_LAST = 6'h2f;
  localparam logic [31:0] VEL_ONE = 32'h0001_0000;
  localparam logic [31:0] VEL_RST = 32'h0000_8000;
  localparam logic signed [15:0] TRIM_MAX = 16'sh4e20;
  localparam logic signed [15:0] TRIM_MIN = -16'sh4e20;
  localparam logic [15:0] ROLE_NORMAL = 16'h0000;
  localparam logic [15:0] ROLE_SLAVE = 16'h00ff;
  localparam logic [15:0] ROLE_REV = 16'hff00;
  localparam logic [15:0] ROLE_MASTER = 16'hffff;
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_MASTER = 8'h08;
  localparam logic [7:0] REG_VEL = 8'h10;
  localparam logic [7:0] REG_SCALE = 8'h20;
  localparam logic [7:0] REG_AXIS = 8'h30;
  localparam logic [7:0] BANK_MASK = 8'hf0;
  localparam logic [7:0] ALIGN_MASK = 8'h03;
  localparam int AXSEL_LSB = 2;
  localparam int AXSEL_MSB = 3;

  typedef enum logic [1:0] {
    PH_STOP = 2'h0, PH_ACCEL = 2'h1, PH_CONST = 2'h2, PH_DECEL = 2'h3
  } phase_t;

  typedef enum logic [3:0] {
    OP_START = 4'h0, OP_STOP = 4'h1, OP_TRIM = 4'h2, OP_ROLE = 4'h3,
    OP_MODE = 4'h4, OP_OFFSET = 4'h5, OP_RESET = 4'h6, OP_MULTI = 4'h7
  } op_t;

  typedef enum logic [3:0] {
    G_IDLE = 4'h1, G_LOAD = 4'h2, G_DIV = 4'h4, G_NEXT = 4'h8
  } gear_st_t;

  typedef struct packed {
    logic [15:0] data;
    logic [9:0] pad;
    logic [1:0] axis;
    logic [3:0] op;
  } cmd_t;

  typedef struct packed {
    logic [13:0] pad;
    logic rel;
    logic vel;
  } mode_t;

  typedef struct packed {
    logic [11:0] high;
    logic [3:0] sel;
  } mask_t;

  typedef struct packed {
    logic [15:0] den;
    logic [15:0] num;
  } scale_t;

  localparam scale_t SCALE_RST = 32'h0001_0001;

  typedef struct packed {
    logic [11:0] pad;
    logic [3:0] not_exec;
    logic [3:0] done;
    logic [3:0] running;
    logic last_ok;
    logic [1:0] pad2;
    logic cmd_err;
    logic [3:0] pad3;
  } stat_t;

  typedef struct packed {
    logic [11:0] pad;
    logic not_exec;
    logic run;
    logic rel;
    logic vel;
    logic [15:0] role;
  } axis_stat_t;

  typedef struct packed {
    logic [31:0] enc_pos;
    phase_t phase;
    logic limit_block;
    logic fault_stop;
    logic move_done;
  } axis_in_t;

  typedef struct packed {
    logic [31:0] vel_cmd;
    logic [31:0] pos_target;
    logic start;
    logic stop;
    logic pos_reset;
    logic slave_run;
  } axis_out_t;
endpackage

// ---- multi_axis_gearing_and_start.sv ----
/*
  Command-level motion logic: velocity trim, master/slave gearing of
  slave targets to the master encoder, and all-or-nothing multi-axis start.
  Assumes axis inputs synchronous to clock; trajectory and servo loops
  sit outside and act on the start/stop/reset pulses and targets.
*/
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/1ps

// Overview of operation
// R01: Trim is signed, clamped to plus or minus 20000 steps per second.
// R02: Trim is ignored unless the axis runs at constant velocity.
// R03: Accepted trim adds to target velocity at once, no ramp.
// R04: A new trim replaces the old one, never accumulates.
// R05: Trim is zeroed when the move completes or is stopped.
// R06: Roles: 0 normal, 00ff slave, ff00 reverse slave, ffff master.
// R07: One master per board; the latest designated master wins.
// R08: Slaves follow master encoder position; reverse slaves invert sign.
// R09: Each slave gears by its own numerator over denominator scale.
// R10: Offset command to a slave adds an offset move on top.
// R11: Slaves stay in position mode; velocity mode request is an error.
// R12: Absolute gears to zero; relative to positions captured on entry or ratio change.
// R13: Position reset of the master resets all slaves with it.
// R14: Slave stopped by fault or switch stays stopped until a start.
// R15: Host must start a slave after configuring it before gearing.
// R16: Slave motion limited by its own velocity setting.
// R17: Multi-start mask: bits 0 to 3 select axes, higher bits zero.
// R18: Multi-start checks all selected axes first; any failure starts none.
// R19: Multi-start with fewer than two axes is a command error.
// R20: Limit-blocked axis sets not-executed status, global and per axis.
// R21: All axes of a successful multi-start start within 100 us.
// R22: Gearing updates once per 341 us sample period.
// R23: Velocity words are 16.16 counts per sample period.
module multi_axis_gearing_and_start
  import gear_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYC
) (
  input logic clock,
  input logic rst_n,
  input logic ce,
  input logic wb_cyc,
  input logic wb_stb,
  input logic wb_we,
  input logic [7:0] wb_adr,
  input logic [3:0] wb_sel,
  input logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack,
  input axis_in_t axis_in [AXES],
  output axis_out_t axis_out [AXES]
);
  localparam int TW = $clog2(SAMPLE_CYCLES + 1);

  function automatic logic is_slave(input logic [15:0] role);
    return (role == ROLE_SLAVE) || (role == ROLE_REV);
  endfunction

  function automatic logic [15:0] clamp_trim(input logic signed [15:0] v);
    if (v > TRIM_MAX) return TRIM_MAX;
    if (v < TRIM_MIN) return TRIM_MIN;
    return v;
  endfunction

  function automatic logic two_or_more(input logic [3:0] m);
    return (32'(m[0]) + 32'(m[1]) + 32'(m[2]) + 32'(m[3])) >= 32'd2;
  endfunction

  function automatic logic [31:0] lane_write(input logic [31:0] old,
                                             input logic [31:0] nd,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[BYTE_W*i +: BYTE_W] = nd[BYTE_W*i +: BYTE_W];
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic ack_reg;
  logic [31:0] rdat_reg;
  cmd_t cmd;
  mode_t mode;
  mask_t mask;
  stat_t clr;
  stat_t sw;
  wire req = wb_cyc & wb_stb;
  wire wr = ce & req & ack_reg & wb_we;
  wire aligned = (wb_adr & ALIGN_MASK) == '0;
  wire [7:0] bank = wb_adr & BANK_MASK;
  wire [1:0] rax = wb_adr[AXSEL_MSB:AXSEL_LSB];
  assign cmd = wb_dat_i;
  assign mode = cmd.data;
  assign mask = cmd.data;
  assign clr = wb_dat_i;
  wire cmd_go = wr & (wb_adr == REG_CMD) & (wb_sel == 4'hf);
  wire stat_wr = wr & (wb_adr == REG_STAT);
  wire go_start = cmd_go & (cmd.op == OP_START);
  wire go_stop = cmd_go & (cmd.op == OP_STOP);
  wire go_trim = cmd_go & (cmd.op == OP_TRIM);
  wire go_role = cmd_go & (cmd.op == OP_ROLE);
  wire go_mode = cmd_go & (cmd.op == OP_MODE);
  wire go_offset = cmd_go & (cmd.op == OP_OFFSET);
  wire go_reset = cmd_go & (cmd.op == OP_RESET);
  wire go_multi = cmd_go & (cmd.op == OP_MULTI);
  wire [3:0] ax_oh = 4'h1 << cmd.axis;

  logic [31:0] vel_a [AXES];
  logic [31:0] scale_a [AXES];
  logic [31:0] astat_a [AXES];
  logic [31:0] tgt_a [AXES];
  logic [31:0] mref_a [AXES];
  logic [31:0] sref_a [AXES];
  logic [31:0] off_a [AXES];
  logic [15:0] role_a [AXES];
  logic [3:0] blk;
  logic [3:0] slv_vec;
  logic [3:0] run_vec;

  //////////////////////////////////////////////////////////////////////////
  // Command checks and status
  logic cmd_err_reg;
  logic last_ok_reg;
  logic [3:0] not_exec_reg;
  logic [1:0] master_ax_reg;
  logic master_ok_reg;
  wire slave_vel_err = go_mode & mode.vel & slv_vec[cmd.axis]; // R11
  wire multi_bad = go_multi & ((|mask.high) | ~two_or_more(mask.sel)); // R17 R19
  wire multi_blk = go_multi & ~multi_bad & (|(mask.sel & blk)); // R18
  wire multi_ok = go_multi & ~multi_bad & ~multi_blk;
  wire single_blk = go_start & blk[cmd.axis];
  wire [3:0] start_vec = (go_start & ~single_blk) ? ax_oh :
                         multi_ok ? mask.sel : 4'h0; // R21
  wire [3:0] ne_set = single_blk ? ax_oh :
                      multi_blk ? (mask.sel & blk) : 4'h0; // R20
  wire err_set = slave_vel_err | multi_bad;
  wire cmd_fail = err_set | (|ne_set);
  wire reset_all = go_reset & master_ok_reg & (cmd.axis == master_ax_reg);
  wire [3:0] rst_vec = go_reset ? (ax_oh | (reset_all ? slv_vec : 4'h0)) : 4'h0; // R13
  wire [3:0] ne_clr = stat_wr ? clr.not_exec : 4'h0;
  wire [31:0] master_pos = axis_in[master_ax_reg].enc_pos; // R08

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cmd_err_reg <= 1'b0;
      last_ok_reg <= 1'b1;
      not_exec_reg <= 4'h0;
      master_ax_reg <= 2'h0;
      master_ok_reg <= 1'b0;
    end else if (ce) begin
      cmd_err_reg <= (cmd_err_reg & ~(stat_wr & clr.cmd_err)) | err_set;
      not_exec_reg <= (not_exec_reg & ~ne_clr) | ne_set; // R20
      if (cmd_go) last_ok_reg <= ~cmd_fail; // R20
      if (go_role && cmd.data == ROLE_MASTER) begin
        master_ax_reg <= cmd.axis; // R07
        master_ok_reg <= 1'b1;
      end else if (go_role && cmd.axis == master_ax_reg) begin
        master_ok_reg <= 1'b0;
      end
    end
  end

  assign sw = '{pad: '0, not_exec: not_exec_reg, done: ~run_vec, running: run_vec,
                last_ok: last_ok_reg, pad2: '0, cmd_err: cmd_err_reg, pad3: '0};
  wire [31:0] rd_mux = (wb_adr == REG_STAT) ? sw :
                       (wb_adr == REG_MASTER) ? 32'({master_ok_reg, master_ax_reg}) :
                       (aligned && bank == REG_VEL) ? vel_a[rax] :
                       (aligned && bank == REG_SCALE) ? scale_a[rax] :
                       (aligned && bank == REG_AXIS) ? astat_a[rax] : '0;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      rdat_reg <= '0;
    end else if (ce) begin
      ack_reg <= req & ~ack_reg;
      if (req && !ack_reg) rdat_reg <= rd_mux;
    end
  end
  assign wb_ack = ack_reg;
  assign wb_dat_o = rdat_reg;

  //////////////////////////////////////////////////////////////////////////
  // Sample tick and shared gear engine
  logic [TW-1:0] tick_reg;
  gear_st_t gst_reg;
  logic [1:0] gax_reg;
  logic [5:0] dcnt_reg;
  logic [16:0] rem_reg;
  logic [PROD_W-1:0] quo_reg;
  logic neg_reg;
  scale_t gsc;
  wire tick = tick_reg == TW'(SAMPLE_CYCLES - 1); // R22
  assign gsc = scale_a[gax_reg];
  wire signed [31:0] gdiff = master_pos - mref_a[gax_reg]; // R12
  wire signed [PROD_W:0] gprod = gdiff * $signed({1'b0, gsc.num}); // R09
  wire gneg = gprod[PROD_W] ^ (role_a[gax_reg] == ROLE_REV); // R08
  wire [PROD_W-1:0] gmag = gprod[PROD_W] ? PROD_W'(-gprod) : gprod[PROD_W-1:0];
  wire [15:0] den = (gsc.den == 16'h0) ? 16'h1 : gsc.den; // R09
  wire [16:0] dsh = {rem_reg[15:0], quo_reg[PROD_W-1]};
  wire dge = dsh >= {1'b0, den};
  wire [16:0] drem = dge ? (dsh - {1'b0, den}) : dsh;
  wire [31:0] gq = quo_reg[31:0];
  wire [31:0] geared = neg_reg ? -gq : gq;
  wire [31:0] goal = geared + sref_a[gax_reg] + off_a[gax_reg]; // R10
  wire signed [31:0] gerr = goal - tgt_a[gax_reg];
  wire [15:0] vint = vel_a[gax_reg][31:VEL_FRAC]; // R23
  wire signed [31:0] lim = {16'h0, (vint == 16'h0) ? 16'h1 : vint}; // R16
  wire [31:0] gstep = (gerr > lim) ? lim : (gerr < -lim) ? -lim : gerr; // R16
  wire gear_wr = ce & (gst_reg == G_NEXT) & master_ok_reg;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tick_reg <= '0;
      gst_reg <= G_IDLE;
      gax_reg <= 2'h0;
      dcnt_reg <= 6'h0;
      rem_reg <= '0;
      quo_reg <= '0;
      neg_reg <= 1'b0;
    end else if (ce) begin
      tick_reg <= tick ? '0 : tick_reg + 1'b1;
      case (gst_reg)
        G_IDLE: begin
          if (tick) gst_reg <= G_LOAD; // R22
        end
        G_LOAD: begin
          rem_reg <= '0;
          quo_reg <= gmag;
          neg_reg <= gneg;
          dcnt_reg <= 6'h0;
          gst_reg <= G_DIV;
        end
        G_DIV: begin
          rem_reg <= drem;
          quo_reg <= {quo_reg[PROD_W-2:0], dge};
          dcnt_reg <= dcnt_reg + 6'h1;
          if (dcnt_reg == DIV_LAST) gst_reg <= G_NEXT;
        end
        G_NEXT: begin
          gax_reg <= gax_reg + 2'h1;
          gst_reg <= (gax_reg == 2'(AXES - 1)) ? G_IDLE : G_LOAD;
        end
        default: gst_reg <= G_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Per-axis state
  for (genvar a = 0; a < AXES; a++) begin : g_ax
    localparam logic [1:0] AX = 2'(a);
    logic [31:0] vel_reg;
    scale_t scale_reg;
    logic [15:0] role_reg;
    logic signed [15:0] trim_reg;
    logic [31:0] off_reg;
    logic [31:0] mref_reg;
    logic [31:0] sref_reg;
    logic velm_reg;
    logic relm_reg;
    axis_out_t out_reg;
    wire sel = cmd.axis == AX;
    wire slv = is_slave(role_reg);
    wire vel_wr = wr & aligned & (bank == REG_VEL) & (rax == AX);
    wire scale_wr = wr & aligned & (bank == REG_SCALE) & (rax == AX);
    wire mode_ok = go_mode & sel & ~slave_vel_err;
    wire trim_go = go_trim & sel & (axis_in[a].phase == PH_CONST); // R02
    wire trim_clr = axis_in[a].move_done | (go_stop & sel) |
                    (axis_in[a].phase == PH_STOP); // R05
    wire capture = (mode_ok & mode.rel & ~relm_reg) | (scale_wr & relm_reg); // R12
    wire fault = axis_in[a].fault_stop | (go_stop & sel);
    wire follow = gear_wr & (gax_reg == AX) & slv & out_reg.slave_run;

    assign vel_a[a] = vel_reg;
    assign scale_a[a] = scale_reg;
    assign role_a[a] = role_reg;
    assign tgt_a[a] = out_reg.pos_target;
    assign off_a[a] = off_reg;
    assign mref_a[a] = relm_reg ? mref_reg : '0;
    assign sref_a[a] = relm_reg ? sref_reg : '0;
    assign blk[a] = axis_in[a].limit_block;
    assign slv_vec[a] = slv;
    assign run_vec[a] = slv ? out_reg.slave_run : (axis_in[a].phase != PH_STOP);
    assign astat_a[a] = axis_stat_t'{pad: '0, not_exec: not_exec_reg[a],
                                     run: run_vec[a], rel: relm_reg, vel: velm_reg,
                                     role: role_reg};
    assign axis_out[a] = out_reg;

    always_ff @(posedge clock) begin
      if (!rst_n) begin
        vel_reg <= VEL_RST;
        scale_reg <= SCALE_RST;
        role_reg <= ROLE_NORMAL;
        trim_reg <= '0;
        off_reg <= '0;
        mref_reg <= '0;
        sref_reg <= '0;
        velm_reg <= 1'b0;
        relm_reg <= 1'b0;
        out_reg <= '0;
      end else if (ce) begin
        if (vel_wr) vel_reg <= lane_write(vel_reg, wb_dat_i, wb_sel);
        if (scale_wr) scale_reg <= lane_write(scale_reg, wb_dat_i, wb_sel); // R09
        if (go_role && sel) role_reg <= cmd.data; // R06
        if (go_role && sel && is_slave(cmd.data)) velm_reg <= 1'b0; // R11
        else if (mode_ok) velm_reg <= mode.vel;
        if (mode_ok) relm_reg <= mode.rel;
        if (trim_clr) trim_reg <= '0; // R05
        else if (trim_go) trim_reg <= clamp_trim(cmd.data); // R01 R04
        if (rst_vec[a]) begin
          off_reg <= '0;
          mref_reg <= '0;
          sref_reg <= '0;
        end else begin
          if (go_offset && sel) off_reg <= 32'($signed(cmd.data)); // R10
          if (capture) begin
            mref_reg <= master_pos;
            sref_reg <= axis_in[a].enc_pos;
          end
        end
        out_reg.vel_cmd <= vel_reg + 32'(trim_reg); // R03
        out_reg.start <= start_vec[a]; // R21
        out_reg.stop <= go_stop & sel;
        out_reg.pos_reset <= rst_vec[a]; // R13
        if (rst_vec[a]) out_reg.pos_target <= '0;
        else if (follow) out_reg.pos_target <= out_reg.pos_target + gstep;
        if (start_vec[a] && slv) out_reg.slave_run <= 1'b1; // R15
        else if (fault || !slv) out_reg.slave_run <= 1'b0; // R14
      end
    end

    a_trim_range: assert property (@(posedge clock) disable iff (!rst_n) // R01
      trim_reg <= TRIM_MAX && trim_reg >= TRIM_MIN)
      else $error("trim outside limits");
    a_trim_ignored: assert property (@(posedge clock) disable iff (!rst_n) // R02
      (ce && go_trim && sel && axis_in[a].phase != PH_CONST) |=> $stable(trim_reg))
      else $error("trim taken outside constant velocity");
    a_trim_speed: assert property (@(posedge clock) disable iff (!rst_n) // R03
      (ce && trim_go && !trim_clr && !vel_wr) ##1 ce |=>
      out_reg.vel_cmd == $past(vel_reg, 2) + 32'($signed(clamp_trim($past(cmd.data, 2)))))
      else $error("trimmed velocity not applied");
    a_trim_cleared: assert property (@(posedge clock) disable iff (!rst_n) // R05
      (ce && axis_in[a].move_done) |=> trim_reg == '0)
      else $error("trim survived end of move");
    a_slave_posmode: assert property (@(posedge clock) disable iff (!rst_n) // R11
      (ce && go_mode && sel && mode.vel && slv) |=> !velm_reg && cmd_err_reg)
      else $error("slave entered velocity mode");
    a_slave_hold: assert property (@(posedge clock) disable iff (!rst_n) // R14
      (ce && axis_in[a].fault_stop && !start_vec[a]) ##1 (!start_vec[a])[*2] |->
      !out_reg.slave_run)
      else $error("slave resumed without start");
  end

  //////////////////////////////////////////////////////////////////////////
  a_master_last: assert property (@(posedge clock) disable iff (!rst_n) // R07
    (ce && go_role && cmd.data == ROLE_MASTER) |=>
    master_ok_reg && master_ax_reg == $past(cmd.axis))
    else $error("latest master not used");
  a_multi_none: assert property (@(posedge clock) disable iff (!rst_n) // R18
    (ce && go_multi && (|(mask.sel & blk))) |=>
    !(axis_out[0].start | axis_out[1].start | axis_out[2].start | axis_out[3].start))
    else $error("partial multi start");
  a_multi_few: assert property (@(posedge clock) disable iff (!rst_n) // R19
    (ce && go_multi && !two_or_more(mask.sel)) |=> cmd_err_reg && !last_ok_reg)
    else $error("short multi start not flagged");
  a_start_sync: assert property (@(posedge clock) disable iff (!rst_n) // R21
    (ce && multi_ok) |=> {axis_out[3].start, axis_out[2].start,
                          axis_out[1].start, axis_out[0].start} == $past(mask.sel))
    else $error("multi start not simultaneous");
  a_block_flag: assert property (@(posedge clock) disable iff (!rst_n) // R20
    (ce && single_blk) |=> not_exec_reg[$past(cmd.axis)] && !last_ok_reg)
    else $error("blocked start not flagged");
  a_gear_rate: assert property (@(posedge clock) disable iff (!rst_n) // R22
    (ce && gst_reg == G_NEXT && gax_reg == 2'h3) |=> gst_reg == G_IDLE)
    else $error("gear pass overran");
endmodule

// ---- host_model.sv ----
/*
  Host side: classic Wishbone master with one transfer task.
  Assumes the bench clock and a slave that acks every request.
*/
`timescale 1ns/1ps
module host_model (
  input wire logic clock,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat,
  input wire logic ack,
  input wire logic [31:0] dat_i
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0;
  end
  ////////////////////////////////////////
  // Request held until ack is sampled high or 64 cycles pass, then one idle cycle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    int n;
    ok = 1'b0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    dat <= d;
    for (n = 0; n < 64 && ok == 1'b0; n++) begin
      @(posedge clock);
      ok = (ack === 1'b1);
    end
    q = dat_i;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clock);
  endtask
endmodule

// ---- multi_axis_gearing_and_start_test.sv ----
/*
  Bench for the trim, gearing and multi-start block.
  Assumes gear_pkg and the host bus model; axis side driven here.
*/
`timescale 1ns/1ps
module multi_axis_gearing_and_start_test;
  import gear_pkg::*;
  localparam int SC = 300;
  logic clock;
  logic rst_n;
  logic ce;
  logic cyc, stb, we, ack, ok, pair;
  logic [7:0] adr;
  logic [3:0] sel, st_seen, rs_seen, sp_seen;
  logic [31:0] dw, dr, q;
  axis_in_t ain [AXES];
  axis_out_t aout [AXES];
  int n_fail = 0;
  int cmp_count = 0;

  multi_axis_gearing_and_start #(.SAMPLE_CYCLES(SC)) DUT (
    .clock(clock), .rst_n(rst_n), .ce(ce), .wb_cyc(cyc), .wb_stb(stb),
    .wb_we(we), .wb_adr(adr), .wb_sel(sel), .wb_dat_i(dw), .wb_dat_o(dr),
    .wb_ack(ack), .axis_in(ain), .axis_out(aout));
  host_model host (
    .clock(clock), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dat(dw), .ack(ack), .dat_i(dr));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Records start and position reset pulses
  always @(posedge clock) begin
    for (int i = 0; i < AXES; i++) begin
      if (aout[i].start === 1'b1) st_seen[i] <= 1'b1;
      if (aout[i].pos_reset === 1'b1) rs_seen[i] <= 1'b1;
      if (aout[i].stop === 1'b1) sp_seen[i] <= 1'b1;
    end
    if (aout[0].start === 1'b1 && aout[1].start === 1'b1) pair <= 1'b1;
  end
  ////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d failures %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    host.xfer(w, a, d, q, ok);
    if (ok !== 1'b1) begin
      n_fail++;
      wrap_up();
    end
  endtask
  task automatic cmd(input op_t op, input logic [1:0] ax, input logic [15:0] d);
    xf(1'b1, REG_CMD, {d, 10'h000, ax, op});
    repeat (2) @(posedge clock);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    xf(1'b0, a, 32'h0);
    chk(nm, e, q & m);
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    rdc("vel0", REG_VEL, 32'hffffffff, VEL_RST);
    rdc("scale1", REG_SCALE + 8'h04, 32'hffffffff, SCALE_RST);
    rdc("stat", REG_STAT, 32'h000f0090, 32'h00000080);
    rdc("unmapped", 8'hfc, 32'hffffffff, 32'h0);
    rdc("role0", REG_AXIS, 32'h0000ffff, {16'h0, ROLE_NORMAL});
  endtask
  task automatic t_trim();
    ain[0].phase <= PH_CONST;
    cmd(OP_TRIM, 2'd0, 16'h7530);
    chk("trim_hi", VEL_RST + 32'd20000, aout[0].vel_cmd);
    cmd(OP_TRIM, 2'd0, 16'hfffb);
    chk("trim_new", VEL_RST - 32'd5, aout[0].vel_cmd);
    cmd(OP_TRIM, 2'd0, 16'h8ad0);
    chk("trim_lo", VEL_RST - 32'd20000, aout[0].vel_cmd);
    ain[0].phase <= PH_ACCEL;
    cmd(OP_TRIM, 2'd0, 16'h0064);
    chk("trim_acc", VEL_RST - 32'd20000, aout[0].vel_cmd);
    ain[0].phase <= PH_DECEL;
    cmd(OP_TRIM, 2'd0, 16'h0064);
    chk("trim_dec", VEL_RST - 32'd20000, aout[0].vel_cmd);
    ain[0].phase <= PH_STOP;
    cmd(OP_TRIM, 2'd0, 16'h0064);
    chk("trim_stop", VEL_RST, aout[0].vel_cmd);
    ain[0].phase <= PH_CONST;
    cmd(OP_TRIM, 2'd0, 16'h0064);
    chk("trim_run", VEL_RST + 32'd100, aout[0].vel_cmd);
    cmd(OP_STOP, 2'd0, 16'h0);
    chk("trim_halt", VEL_RST, aout[0].vel_cmd);
    chk("stop_pulse", 32'h1, {31'h0, sp_seen[0]});
    cmd(OP_TRIM, 2'd0, 16'h0064);
    ain[0].move_done <= 1'b1;
    @(posedge clock);
    ain[0].move_done <= 1'b0;
    repeat (2) @(posedge clock);
    chk("trim_done", VEL_RST, aout[0].vel_cmd);
  endtask
  task automatic t_multi();
    pair <= 1'b0;
    cmd(OP_MULTI, 2'd0, 16'h0003);
    chk("multi_ok", 32'h3, {28'h0, st_seen});
    chk("multi_same", 32'h1, {31'h0, pair});
    rdc("multi_err", REG_STAT, 32'h10, 32'h0);
    st_seen <= 4'h0;
    cmd(OP_MULTI, 2'd0, 16'h0004);
    rdc("one_axis", REG_STAT, 32'h10, 32'h10);
    xf(1'b1, REG_STAT, 32'hffffffff);
    cmd(OP_MULTI, 2'd0, 16'h0013);
    rdc("high_bits", REG_STAT, 32'h10, 32'h10);
    xf(1'b1, REG_STAT, 32'hffffffff);
    ain[1].limit_block <= 1'b1;
    cmd(OP_MULTI, 2'd0, 16'h0006);
    rdc("blocked", REG_STAT, 32'h000f0080, 32'h00020000);
    rdc("blk_axis", REG_AXIS + 8'h04, 32'h00080000, 32'h00080000);
    chk("none_start", 32'h0, {28'h0, st_seen});
    ain[1].limit_block <= 1'b0;
    xf(1'b1, REG_STAT, 32'hffffffff);
  endtask
  task automatic t_gear();
    cmd(OP_ROLE, 2'd3, ROLE_MASTER);
    cmd(OP_ROLE, 2'd0, ROLE_MASTER);
    rdc("master", REG_MASTER, 32'h7, 32'h4);
    cmd(OP_ROLE, 2'd1, ROLE_SLAVE);
    cmd(OP_ROLE, 2'd2, ROLE_REV);
    cmd(OP_MODE, 2'd1, 16'h0001);
    rdc("slave_vel", REG_STAT, 32'h10, 32'h10);
    rdc("slave_ax", REG_AXIS + 8'h04, 32'h0003ffff, {16'h0, ROLE_SLAVE});
    xf(1'b1, REG_SCALE + 8'h04, 32'h00020003);
    xf(1'b1, REG_VEL + 8'h04, 32'h00ff0000);
    xf(1'b1, REG_VEL + 8'h08, 32'h00ff0000);
    ain[0].enc_pos <= 32'd100;
    repeat (2 * SC) @(posedge clock);
    chk("no_start", 32'h0, aout[1].pos_target);
    cmd(OP_START, 2'd1, 16'h0);
    cmd(OP_START, 2'd2, 16'h0);
    repeat (3 * SC) @(posedge clock);
    chk("slave", 32'd150, aout[1].pos_target);
    chk("rev", -32'sd100, aout[2].pos_target);
    cmd(OP_OFFSET, 2'd1, 16'h000a);
    repeat (3 * SC) @(posedge clock);
    chk("offset", 32'd160, aout[1].pos_target);
    cmd(OP_MODE, 2'd1, 16'h0002);
    ain[0].enc_pos <= 32'd104;
    repeat (3 * SC) @(posedge clock);
    chk("rel", 32'd16, aout[1].pos_target);
    rs_seen <= 4'h0;
    ain[0].enc_pos <= 32'h0;
    cmd(OP_RESET, 2'd0, 16'h0);
    chk("reset", 32'h7, {28'h0, rs_seen});
    ain[1].fault_stop <= 1'b1;
    @(posedge clock);
    ain[1].fault_stop <= 1'b0;
    repeat (SC) @(posedge clock);
    chk("fault", 32'h0, {31'h0, aout[1].slave_run});
    cmd(OP_START, 2'd1, 16'h0);
    chk("restart", 32'h1, {31'h0, aout[1].slave_run});
    xf(1'b1, REG_VEL + 8'h08, VEL_ONE);
    ain[0].enc_pos <= 32'd50;
    for (int i = 0; i < 4 * SC && aout[2].pos_target === 32'h0; i++) @(posedge clock);
    chk("vel_step", -32'sd1, aout[2].pos_target);
    repeat (2 * SC) @(posedge clock);
    chk("vel_lim", -32'sd3, aout[2].pos_target);
  endtask
  ////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    for (int i = 0; i < AXES; i++) ain[i] = '0;
    st_seen = 4'h0;
    rs_seen = 4'h0;
    sp_seen = 4'h0;
    pair = 1'b0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_trim();
    t_multi();
    t_gear();
    wrap_up();
  end
endmodule
